// ==== verilog/ncb_pkg.sv ====
// package of the nonlinearity coefficient bank: register map, field layout, reset values
// assumes a device clock and a synchronous active-high reset in every user
package ncb_pkg;

	// ==========================================================================
	// register map (device register addresses, 8-bit)
	// ==========================================================================
	localparam logic [7:0] QUARTIC_LOW_CH1_LO_AND_QUAD_LOW_CH1_ADDR     = 8'had;
	localparam logic [7:0] QUARTIC_HIGH_CH1_HI_AND_QUAD_HIGH_CH1_ADDR   = 8'hae;
	localparam logic [7:0] QUARTIC_HIGH_CH1_LO_AND_QUAD_LOW_CH2_ADDR    = 8'haf;
	localparam logic [7:0] QUARTIC_LOW_CH2_HI_AND_QUAD_HIGH_CH2_ADDR    = 8'hb0;
	localparam logic [7:0] QUARTIC_LOW_CH2_LO_AND_CUBIC_HIGH_CH0_ADDR   = 8'hb1;
	localparam logic [7:0] QUARTIC_HIGH_CH2_COEFFICIENT_ADDR            = 8'hb2;

	localparam int unsigned REG_COUNT   = 6;
	localparam int unsigned INDEX_WIDTH = 3;
	localparam int unsigned REG_WIDTH   = 24;
	localparam int unsigned COEF_WIDTH  = 16;
	localparam int unsigned BYTE_WIDTH  = 8;

	// register indices, in address order from the first register of the bank
	localparam logic [INDEX_WIDTH-1:0] IDX_WORD0 = 3'h0;
	localparam logic [INDEX_WIDTH-1:0] IDX_WORD1 = 3'h1;
	localparam logic [INDEX_WIDTH-1:0] IDX_WORD2 = 3'h2;
	localparam logic [INDEX_WIDTH-1:0] IDX_WORD3 = 3'h3;
	localparam logic [INDEX_WIDTH-1:0] IDX_WORD4 = 3'h4;
	localparam logic [INDEX_WIDTH-1:0] IDX_WORD5 = 3'h5;

	// ==========================================================================
	// field layout and reset values
	// ==========================================================================
	localparam int unsigned COEF_LSB  = 0;   // 16-bit coefficient field 15:0
	localparam int unsigned COEF_MSB  = 15;
	localparam int unsigned SPLIT_LSB = 16;  // split quartic byte 23:16
	localparam int unsigned SPLIT_MSB = 23;

	localparam logic [REG_WIDTH-1:0]  REG_RESET      = 24'h000000;
	localparam logic [REG_WIDTH-1:0]  RESV_WRITE_MASK = 24'h00ffff; // reserved byte held at zero
	localparam logic [REG_WIDTH-1:0]  FULL_MASK      = 24'hffffff;
	localparam logic [COEF_WIDTH-1:0] COEF_ZERO      = 16'h0000;

	// ==========================================================================
	// channel encodings
	// ==========================================================================
	localparam logic [1:0] CHANNEL_0 = 2'h0;
	localparam logic [1:0] CHANNEL_1 = 2'h1;
	localparam logic [1:0] CHANNEL_2 = 2'h2;

endpackage

// ==== verilog/ncb_split_join.sv ====
// joins a fourth-order coefficient split over two registers of the bank
// assumes both register words are stable flip-flop outputs of the caller
`timescale 1ns/1ps
`default_nettype none

module ncb_split_join (
	input  wire logic [23:0] upper_word,
	input  wire logic [23:0] lower_word,
	output logic      [15:0] quartic_coef
);

	// upper byte from the lower address, lower byte from the next address
	assign quartic_coef = {upper_word[ncb_pkg::SPLIT_MSB:ncb_pkg::SPLIT_LSB],
		lower_word[ncb_pkg::SPLIT_MSB:ncb_pkg::SPLIT_LSB]};

endmodule

`default_nettype wire

// ==== verilog/ncb_nonlinearity_coeff_bank.sv ====
// nonlinearity coefficient bank: six 24-bit read/write coefficient registers
// assumes the host control port delivers one complete 24-bit word per write strobe,
// and that the first quartic byte of low-current channel 1 lives in a neighbouring
// register outside this bank and arrives on quartic_low_ch1_hi_byte
//
// Overview of operation
// - second-order coefficients sit in bits 15:0
// - split quartic upper byte from lower address
// - split quartic lower byte from next address
// - channel 2 high quartic register reserved byte 23:16 reads zero
// - all coefficient fields reset to zero
// - select set by channel and drive level
// - channel 0 high cubic sits in 15:0
// - channel 2 high quartic unsplit in 15:0
`timescale 1ns/1ps
`default_nettype none

module ncb_nonlinearity_coeff_bank (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        host_wr_en,
	input  wire logic [7:0]  host_wr_addr,
	input  wire logic [23:0] host_wr_data,
	input  wire logic        host_rd_en,
	input  wire logic [7:0]  host_rd_addr,
	output logic      [23:0] host_rd_data,
	output logic             host_rd_valid,
	output logic             host_rd_hit,
	input  wire logic [7:0]  quartic_low_ch1_hi_byte,
	input  wire logic [1:0]  active_channel,
	input  wire logic        high_current,
	output logic      [15:0] sel_quad_coef,
	output logic      [15:0] sel_cubic_coef,
	output logic      [15:0] sel_quartic_coef,
	output logic             sel_quad_present,
	output logic             sel_cubic_present,
	output logic             sel_quartic_present
);

	// ==========================================================================
	// address decoding
	// ==========================================================================

	// true when the address falls on one of the six bank registers
	function automatic logic addr_hit(input logic [7:0] addr);
		addr_hit = (addr >= ncb_pkg::QUARTIC_LOW_CH1_LO_AND_QUAD_LOW_CH1_ADDR)
			&& (addr <= ncb_pkg::QUARTIC_HIGH_CH2_COEFFICIENT_ADDR);
	endfunction

	// register index of an address, only meaningful when addr_hit holds
	function automatic logic [2:0] addr_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - ncb_pkg::QUARTIC_LOW_CH1_LO_AND_QUAD_LOW_CH1_ADDR;
		addr_index = diff[2:0];
	endfunction

	// ==========================================================================
	// register storage
	// ==========================================================================
	logic [23:0] coef_reg [ncb_pkg::REG_COUNT];
	logic        wr_hit;
	logic [2:0]  wr_index;

	assign wr_hit   = host_wr_en && addr_hit(host_wr_addr);
	assign wr_index = addr_index(host_wr_addr);

	// each register but the last takes the whole word in the cycle of its write strobe
	genvar gi;
	generate
		for (gi = 0; gi < ncb_pkg::REG_COUNT; gi++) begin : g_reg
			// the last register keeps its reserved upper byte at zero
			localparam logic [23:0] MASK = (gi == ncb_pkg::IDX_WORD5) ?
				ncb_pkg::RESV_WRITE_MASK : ncb_pkg::FULL_MASK;
			always_ff @(posedge core_clk) begin
				if (rst) begin
					coef_reg[gi] <= ncb_pkg::REG_RESET;
				end else if (wr_hit && (wr_index == 3'(gi))) begin
					coef_reg[gi] <= host_wr_data & MASK;
				end
			end
		end
	endgenerate

	// ==========================================================================
	// host read port
	// ==========================================================================

	// read data is registered and valid one cycle after the read strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			host_rd_data  <= ncb_pkg::REG_RESET;
			host_rd_valid <= 1'b0;
			host_rd_hit   <= 1'b0;
		end else begin
			host_rd_valid <= host_rd_en;
			host_rd_hit   <= host_rd_en && addr_hit(host_rd_addr);
			if (host_rd_en && addr_hit(host_rd_addr)) begin
				host_rd_data <= coef_reg[addr_index(host_rd_addr)];
			end else if (host_rd_en) begin
				host_rd_data <= ncb_pkg::REG_RESET;                       // unmapped reads zero
			end
		end
	end

	// ==========================================================================
	// coefficient fields
	// ==========================================================================
	logic [15:0] quad_coef_low_current_ch1;
	logic [15:0] quad_coef_high_current_ch1;
	logic [15:0] quad_coef_low_current_ch2;
	logic [15:0] quad_coef_high_current_ch2;
	logic [15:0] cubic_coef_high_current_ch0;
	logic [15:0] quartic_coef_low_current_ch1;
	logic [15:0] quartic_coef_high_current_ch1;
	logic [15:0] quartic_coef_low_current_ch2;
	logic [15:0] quartic_coef_high_current_ch2;

	// 16-bit fields in the low bits of their registers
	assign quad_coef_low_current_ch1 =
		coef_reg[ncb_pkg::IDX_WORD0][ncb_pkg::COEF_MSB:ncb_pkg::COEF_LSB];
	assign quad_coef_high_current_ch1 =
		coef_reg[ncb_pkg::IDX_WORD1][ncb_pkg::COEF_MSB:ncb_pkg::COEF_LSB];
	assign quad_coef_low_current_ch2 =
		coef_reg[ncb_pkg::IDX_WORD2][ncb_pkg::COEF_MSB:ncb_pkg::COEF_LSB];
	assign quad_coef_high_current_ch2 =
		coef_reg[ncb_pkg::IDX_WORD3][ncb_pkg::COEF_MSB:ncb_pkg::COEF_LSB];
	assign cubic_coef_high_current_ch0 =
		coef_reg[ncb_pkg::IDX_WORD4][ncb_pkg::COEF_MSB:ncb_pkg::COEF_LSB];
	assign quartic_coef_high_current_ch2 =
		coef_reg[ncb_pkg::IDX_WORD5][ncb_pkg::COEF_MSB:ncb_pkg::COEF_LSB];

	// low-current channel 1 quartic: upper byte from the neighbour below the bank
	assign quartic_coef_low_current_ch1 = {quartic_low_ch1_hi_byte,
		coef_reg[ncb_pkg::IDX_WORD0][ncb_pkg::SPLIT_MSB:ncb_pkg::SPLIT_LSB]};

	// split quartic pairs held wholly inside the bank
	ncb_split_join u_join_high_ch1 (
		.upper_word   (coef_reg[ncb_pkg::IDX_WORD1]),
		.lower_word   (coef_reg[ncb_pkg::IDX_WORD2]),
		.quartic_coef (quartic_coef_high_current_ch1)
	);

	ncb_split_join u_join_low_ch2 (
		.upper_word   (coef_reg[ncb_pkg::IDX_WORD3]),
		.lower_word   (coef_reg[ncb_pkg::IDX_WORD4]),
		.quartic_coef (quartic_coef_low_current_ch2)
	);

	// ==========================================================================
	// coefficient set selection
	// ==========================================================================
	logic [15:0] quad_next;
	logic [15:0] cubic_next;
	logic [15:0] quartic_next;
	logic        quad_present_next;
	logic        cubic_present_next;
	logic        quartic_present_next;

	// pick the set of the active channel at its drive level; terms stored
	// outside this bank read as zero with their present flag low
	always_comb begin
		quad_next            = ncb_pkg::COEF_ZERO;
		cubic_next           = ncb_pkg::COEF_ZERO;
		quartic_next         = ncb_pkg::COEF_ZERO;
		quad_present_next    = 1'b0;
		cubic_present_next   = 1'b0;
		quartic_present_next = 1'b0;
		case (active_channel)
			ncb_pkg::CHANNEL_0: begin
				if (high_current) begin
					cubic_next         = cubic_coef_high_current_ch0;
					cubic_present_next = 1'b1;
				end
			end
			ncb_pkg::CHANNEL_1: begin
				quad_present_next    = 1'b1;
				quartic_present_next = 1'b1;
				if (high_current) begin
					quad_next    = quad_coef_high_current_ch1;
					quartic_next = quartic_coef_high_current_ch1;
				end else begin
					quad_next    = quad_coef_low_current_ch1;
					quartic_next = quartic_coef_low_current_ch1;
				end
			end
			ncb_pkg::CHANNEL_2: begin
				quad_present_next    = 1'b1;
				quartic_present_next = 1'b1;
				if (high_current) begin
					quad_next    = quad_coef_high_current_ch2;
					quartic_next = quartic_coef_high_current_ch2;
				end else begin
					quad_next    = quad_coef_low_current_ch2;
					quartic_next = quartic_coef_low_current_ch2;
				end
			end
			default: begin
				quad_next = ncb_pkg::COEF_ZERO;                           // no fourth channel
			end
		endcase
	end

	// selected coefficients registered, one cycle behind channel and level
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sel_quad_coef       <= ncb_pkg::COEF_ZERO;
			sel_cubic_coef      <= ncb_pkg::COEF_ZERO;
			sel_quartic_coef    <= ncb_pkg::COEF_ZERO;
			sel_quad_present    <= 1'b0;
			sel_cubic_present   <= 1'b0;
			sel_quartic_present <= 1'b0;
		end else begin
			sel_quad_coef       <= quad_next;
			sel_cubic_coef      <= cubic_next;
			sel_quartic_coef    <= quartic_next;
			sel_quad_present    <= quad_present_next;
			sel_cubic_present   <= cubic_present_next;
			sel_quartic_present <= quartic_present_next;
		end
	end

endmodule

`default_nettype wire

// ==== tb/ncb_monitor.sv ====
// checker of the coefficient bank ports: read answer, address map, set selection
// assumes it is bound onto ncb_nonlinearity_coeff_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ncb_monitor (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        host_wr_en,
	input wire logic [7:0]  host_wr_addr,
	input wire logic [23:0] host_wr_data,
	input wire logic        host_rd_en,
	input wire logic [7:0]  host_rd_addr,
	input wire logic [23:0] host_rd_data,
	input wire logic        host_rd_valid,
	input wire logic        host_rd_hit,
	input wire logic [7:0]  quartic_low_ch1_hi_byte,
	input wire logic [1:0]  active_channel,
	input wire logic        high_current,
	input wire logic [15:0] sel_quartic_coef,
	input wire logic        sel_quad_present,
	input wire logic        sel_cubic_present,
	input wire logic        sel_quartic_present
);
	// ==========================================================================
	// register port
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	rd_answer_a: assert property (host_rd_en |=> host_rd_valid)
		else $error("read strobe got no valid");
	hit_map_a: assert property (host_rd_en |=> host_rd_hit == ($past(host_rd_addr) >= 8'had
		&& $past(host_rd_addr) <= 8'hb2)) else $error("read hit wrong for address");
	unmapped_zero_a: assert property (host_rd_en && host_rd_addr > 8'hb2 |=> host_rd_data == 24'h0)
		else $error("unmapped read not zero");
	reserved_zero_a: assert property (host_rd_en && host_rd_addr == 8'hb2 |=> host_rd_data[23:16] == 8'h0)
		else $error("reserved byte not zero");
	rd_hold_a: assert property (!host_rd_en |=> $stable(host_rd_data))
		else $error("read data moved without a read");
	write_read_a: assert property (host_wr_en && host_wr_addr inside {[8'had:8'hb1]} ##1 !host_wr_en
		##1 host_rd_en && host_rd_addr == $past(host_wr_addr, 2) |=> host_rd_data == $past(host_wr_data, 3))
		else $error("read back differs from write");
	reset_clear_a: assert property (disable iff (1'b0) rst |=> !host_rd_valid && !host_rd_hit
		&& host_rd_data == 24'h0 && sel_quartic_coef == 16'h0) else $error("reset left state");
	// ==========================================================================
	// set selection
	low_quartic_a: assert property (active_channel == 2'h1 && !high_current
		|=> sel_quartic_coef[15:8] == $past(quartic_low_ch1_hi_byte)) else $error("ch1 low upper byte");
	two_terms_a: assert property (active_channel inside {2'h1, 2'h2} |=> sel_quad_present
		&& sel_quartic_present && !sel_cubic_present) else $error("ch1 ch2 term flags wrong");
	cubic_only_a: assert property (active_channel == 2'h0 && high_current |=> sel_cubic_present
		&& !sel_quad_present && !sel_quartic_present) else $error("ch0 high flags wrong");
	no_terms_a: assert property (active_channel == 2'h3 || (active_channel == 2'h0 && !high_current)
		|=> !(sel_quad_present || sel_cubic_present || sel_quartic_present)) else $error("flags not clear");
	cover property (host_rd_en && host_rd_addr == 8'hb2);
	cover property (active_channel == 2'h1 && high_current);
	cover property (host_wr_en && host_wr_addr == 8'hb3);
endmodule
`default_nettype wire

// ==== tb/ncb_nonlinearity_coeff_bank_test.sv ====
// self-checking bench of the coefficient bank: corner and random register traffic
// assumes the package, design and monitor are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module ncb_nonlinearity_coeff_bank_test;
	logic        core_clk, rst, host_wr_en, host_rd_en, high_current;
	logic [7:0]  host_wr_addr, host_rd_addr, quartic_low_ch1_hi_byte;
	logic [23:0] host_wr_data, host_rd_data;
	logic        host_rd_valid, host_rd_hit, sel_quad_present, sel_cubic_present, sel_quartic_present;
	logic [1:0]  active_channel;
	logic [15:0] sel_quad_coef, sel_cubic_coef, sel_quartic_coef;
	logic [23:0] model [6];
	int          fails, checks_done, cycles;
	ncb_nonlinearity_coeff_bank ncb_nonlinearity_coeff_bank_i (.core_clk, .rst, .host_wr_en,
		.host_wr_addr, .host_wr_data, .host_rd_en, .host_rd_addr, .host_rd_data, .host_rd_valid,
		.host_rd_hit, .quartic_low_ch1_hi_byte, .active_channel, .high_current, .sel_quad_coef,
		.sel_cubic_coef, .sel_quartic_coef, .sel_quad_present, .sel_cubic_present, .sel_quartic_present);
	// ==========================================================================
	// checking helpers
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [23:0] exp_rd(input logic [7:0] a);
		if (a < 8'had || a > 8'hb2) return 24'h0;
		return model[a - 8'had];
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================================================
	// host port tasks, strobe for one cycle then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		host_wr_en = 1'b1;
		host_wr_addr = a;
		host_wr_data = d;
		if (a >= 8'had && a <= 8'hb2) model[a - 8'had] = (a == 8'hb2) ? (d & 24'h00ffff) : d;
		@(negedge core_clk);
		host_wr_en = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		host_rd_en = 1'b1;
		host_rd_addr = a;
		@(negedge core_clk);
		host_rd_en = 1'b0;
		chk("read valid", 24'h1, {23'h0, host_rd_valid});
		chk("read hit", {23'h0, a >= 8'had && a <= 8'hb2}, {23'h0, host_rd_hit});
		chk("read data", exp_rd(a), host_rd_data);
		@(negedge core_clk);
	endtask
	// selection: expected set from channel, level and the stored words
	task automatic sel(input logic [1:0] ch, input logic hc, input logic [7:0] hb);
		logic [15:0] q, c, r;
		logic [2:0]  p;
		active_channel = ch;
		high_current = hc;
		quartic_low_ch1_hi_byte = hb;
		@(negedge core_clk);
		q = 16'h0;
		c = 16'h0;
		r = 16'h0;
		p = 3'h0;
		if (ch == 2'h1) begin
			q = hc ? model[1][15:0] : model[0][15:0];
			r = hc ? {model[1][23:16], model[2][23:16]} : {hb, model[0][23:16]};
			p = 3'h5;
		end else if (ch == 2'h2) begin
			q = hc ? model[3][15:0] : model[2][15:0];
			r = hc ? model[5][15:0] : {model[3][23:16], model[4][23:16]};
			p = 3'h5;
		end else if (ch == 2'h0 && hc) begin
			c = model[4][15:0];
			p = 3'h2;
		end
		chk("quad coef", {8'h0, q}, {8'h0, sel_quad_coef});
		chk("cubic coef", {8'h0, c}, {8'h0, sel_cubic_coef});
		chk("quartic coef", {8'h0, r}, {8'h0, sel_quartic_coef});
		chk("presence", {21'h0, p}, {21'h0, sel_quad_present, sel_cubic_present, sel_quartic_present});
	endtask
	// ==========================================================================
	// clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			give_verdict();
		end
	end
	// ==========================================================================
	// main sequence
	initial begin
		rst = 1'b1;
		{host_wr_en, host_rd_en, high_current, active_channel} = 5'h00;
		{host_wr_addr, host_rd_addr, quartic_low_ch1_hi_byte, host_wr_data} = 48'h0;
		for (int i = 0; i < 6; i++) model[i] = 24'h0;
		void'($urandom(32'h9e1b));
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		for (int i = 0; i < 8; i++) rd(8'hac + 8'(i));
		wr(8'hb2, 24'hffffff);
		rd(8'hb2);
		for (int i = 0; i < 6; i++) wr(8'had + 8'(i), 24'(i * 24'h2468ad + 24'h13579b));
		for (int i = 0; i < 8; i++) sel(2'(i >> 1), i[0], 8'h5a);
		repeat (300) begin
			wr(8'hac + 8'($urandom_range(7)), 24'($urandom));
			rd(8'hac + 8'($urandom_range(7)));
			sel(2'($urandom_range(3)), 1'($urandom_range(1)), 8'($urandom));
		end
		// mid-run reset must clear every word written above
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		for (int i = 0; i < 6; i++) model[i] = 24'h0;
		for (int i = 0; i < 8; i++) rd(8'hac + 8'(i));
		sel(2'h1, 1'b1, 8'h00);
		sel(2'h2, 1'b1, 8'h00);
		give_verdict();
	end
endmodule
bind ncb_nonlinearity_coeff_bank ncb_monitor ncb_monitor_i (.core_clk, .rst, .host_wr_en,
	.host_wr_addr, .host_wr_data, .host_rd_en, .host_rd_addr, .host_rd_data, .host_rd_valid,
	.host_rd_hit, .quartic_low_ch1_hi_byte, .active_channel, .high_current, .sel_quartic_coef,
	.sel_quad_present, .sel_cubic_present, .sel_quartic_present);
`default_nettype wire
